/* xve_map.svh */
// Constant map for the exception vector entry block
`ifndef XVE_MAP_SVH
`define XVE_MAP_SVH
`define XVE_VEC_RESET_NMI   32'hBFC0_0000
`define XVE_VEC_DBG_NOPROBE 32'hBFC0_0480
`define XVE_VEC_DBG_PROBE   32'hFF20_0200
`define XVE_VEC_GEN_BEV0    32'h8000_0180
`define XVE_VEC_INT_BEV0_IV 32'h8000_0200
`define XVE_VEC_GEN_BEV1    32'hBFC0_0380
`define XVE_VEC_INT_BEV1_IV 32'hBFC0_0400
`define XVE_RST_BOOT_VEC    1'b1
`define XVE_RST_IVSPLIT     1'b0
`define XVE_RST_ERL         1'b1
`define XVE_RST_SHADOW      4'h0
`define XVE_RST_CAUSE       5'h00
`define XVE_RST_WDSEL       1'b0
`define XVE_RST_BUS_ERROR_RESPONSE_CTRL      1'b0
`define XVE_RST_NMISENSE    2'h0
`define XVE_CLK_NS          25
`endif

/* xve_pkg.sv */
// Types shared by the exception vector entry block
package xve_pkg;
    typedef enum logic [1:0] {
        XVE_SENSE_OFF,
        XVE_SENSE_FALL,
        XVE_SENSE_RISE,
        XVE_SENSE_LOW
    } xve_sense_t;

    typedef enum logic [2:0] {
        XVE_EV_NONE,
        XVE_EV_RESET,
        XVE_EV_NMI,
        XVE_EV_DEBUG,
        XVE_EV_GENERAL
    } xve_event_t;

    typedef struct packed {
        logic        is_int;
        logic [4:0]  cause;
        logic        addr_err;
        logic        bus_err;
        logic        async_data;
        logic        dma;
        logic        is_load;
        logic [31:0] bad_addr;
    } xve_gen_req_t;

    typedef struct packed {
        logic [2:0] nmi_pin_sense;
        logic       boot_vec;
    } xve_dummy_t;
endpackage

/* xve_entry.sv */
// Exception vector selection and entry bookkeeping
//
// Behaviour
// - Reset and NMI vector to BFC00000
// - Debug vector chosen by probe enable
// - Interrupt vector from boot and split bits
// - General vector from boot-vector bit
// - Reset from low pin or watchdog
// - Reset initialises state, saves PC, jumps
// - Reset sets error level; software clears
// - Flash variant: power-on-only registers
// - Mask variant: pin-only registers on watchdog
// - NMI from pin, watchdog or store error
// - NMI sets error level and NMI bits
// - NMI saves current PC to reset-return
// - NMI/general copy current to previous set
// - Separate watchdog and store-error NMI flags
// - General exception records cause code
// - General exception saves PC to exception-return
// - Address/bus errors capture faulting address
// - No DMA load/store address errors
// - Load or DMA load bus error raises exception
// - Debug exceptions skip shadow bookkeeping
// - Watchdog select: reset, or NMI then reset
`timescale 1ns/1ps
`include "xve_map.svh"
module xve_entry
    import xve_pkg::*;
#(
    parameter int unsigned SHADOW_W = 4,
    parameter bit          FLASH_VARIANT = 1'b1
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                power_on_reset,
    input  wire logic                reset_pin_n,
    input  wire logic                wdt_timeout,
    input  wire logic                wdt_overflow,
    input  wire logic                nmi_pin,
    input  wire logic                nmi_pin_function_bit,
    input  wire logic                store_bus_error,
    input  wire logic                debug_req,
    input  wire logic                debug_probe_enable,
    input  wire logic                gen_req,
    input  wire xve_gen_req_t        gen_info,
    input  wire logic [31:0]         current_pc,
    input  wire logic                eret,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [31:0]         reg_rdata,
    output logic                     entry_valid,
    output logic      [31:0]         entry_vector,
    output xve_event_t               entry_kind,
    output logic                     periph_init,
    output logic                     dma_conf_error
);
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_CAUSE  = 8'h04;
    localparam logic [7:0] A_EPC    = 8'h08;
    localparam logic [7:0] A_ERREPC = 8'h0C;
    localparam logic [7:0] A_BADVA  = 8'h10;
    localparam logic [7:0] A_SHADOW = 8'h14;
    localparam logic [7:0] A_NMICFG = 8'h18;
    localparam logic [7:0] A_NMI_CAUSE_FLAGS = 8'h1C;
    localparam logic [7:0] A_MODE   = 8'h20;
    localparam logic [7:0] A_KEEP   = 8'h24;

    if (SHADOW_W < 1 || SHADOW_W > 8) begin : g_bad_shadow_w
        $error("SHADOW_W out of range");
    end

    // Architectural state
    logic                boot_vec_q, boot_vec_d;
    logic                iv_split_q, iv_split_d;
    logic                erl_q, erl_d;
    logic                nmi_bit_q, nmi_bit_d;
    logic [4:0]          cause_q, cause_d;
    logic [31:0]         epc_q, epc_d;
    logic [31:0]         err_epc_q, err_epc_d;
    logic [31:0]         bad_q, bad_d;
    logic [SHADOW_W-1:0] css_q, css_d;
    logic [SHADOW_W-1:0] pss_q, pss_d;
    logic                ssd_q, ssd_d;
    logic [1:0]          sense_q, sense_d;
    logic                wdsel_q, wdsel_d;
    logic                bus_error_response_ctrl_q, bus_error_response_ctrl_d;
    logic                flg_wdt_q, flg_wdt_d;
    logic                flg_store_bus_error_flag_q, flg_store_bus_error_flag_d;
    logic                wdt_nmi_done_q, wdt_nmi_done_d;
    logic                nmi_pin_q, nmi_pin_d;
    logic [31:0]         keep_q, keep_d;
    logic [31:0]         rdata_d;
    logic                valid_d, pinit_d, dmaerr_d;
    logic [31:0]         vec_d;
    xve_event_t          kind_d;

    logic wdt_reset_ev, wdt_nmi_ev, pin_nmi_ev, reset_ev, nmi_ev, dbg_ev, gen_ev;
    logic dma_addr_err;

    always_comb begin
        // Watchdog either resets directly, or first raises NMI then resets on overflow
        wdt_reset_ev = (wdt_timeout && wdsel_q) || (wdt_overflow && wdt_nmi_done_q);
        wdt_nmi_ev   = wdt_timeout && !wdsel_q;
        reset_ev     = !reset_pin_n || wdt_reset_ev;
        unique case (xve_sense_t'(sense_q))
            XVE_SENSE_FALL: pin_nmi_ev = nmi_pin_q && !nmi_pin;
            XVE_SENSE_RISE: pin_nmi_ev = !nmi_pin_q && nmi_pin;
            XVE_SENSE_LOW:  pin_nmi_ev = !nmi_pin;
            XVE_SENSE_OFF:  pin_nmi_ev = 1'b0;
        endcase
        pin_nmi_ev = pin_nmi_ev && nmi_pin_function_bit;
        nmi_ev = pin_nmi_ev || wdt_nmi_ev || (store_bus_error && !bus_error_response_ctrl_q);
        dbg_ev = debug_req;
        // DMA address errors go to the DMA flag, not an exception
        dma_addr_err = gen_req && gen_info.addr_err && gen_info.dma;
        gen_ev = gen_req && !dma_addr_err;
    end

    always_comb begin
        boot_vec_d = boot_vec_q;
        iv_split_d = iv_split_q;
        erl_d = erl_q;
        nmi_bit_d = nmi_bit_q;
        cause_d = cause_q;
        epc_d = epc_q;
        err_epc_d = err_epc_q;
        bad_d = bad_q;
        css_d = css_q;
        pss_d = pss_q;
        ssd_d = ssd_q;
        sense_d = sense_q;
        wdsel_d = wdsel_q;
        bus_error_response_ctrl_d = bus_error_response_ctrl_q;
        flg_wdt_d = flg_wdt_q;
        flg_store_bus_error_flag_d = flg_store_bus_error_flag_q;
        wdt_nmi_done_d = wdt_nmi_done_q;
        nmi_pin_d = nmi_pin;
        keep_d = keep_q;
        valid_d = 1'b0;
        pinit_d = 1'b0;
        dmaerr_d = dma_addr_err;
        vec_d = entry_vector;
        kind_d = XVE_EV_NONE;
        rdata_d = 32'h0000_0000;

        if (reg_read) begin
            unique case (reg_addr)
                A_STATUS: rdata_d = {28'h0, nmi_bit_q, erl_q, iv_split_q, boot_vec_q};
                A_CAUSE:  rdata_d = {27'h0, cause_q};
                A_EPC:    rdata_d = epc_q;
                A_ERREPC: rdata_d = err_epc_q;
                A_BADVA:  rdata_d = bad_q;
                A_SHADOW: rdata_d = {15'h0, ssd_q, 8'(pss_q), 8'(css_q)};
                A_NMICFG: rdata_d = {29'h0, wdsel_q, sense_q};
                A_NMI_CAUSE_FLAGS: rdata_d = {30'h0, flg_store_bus_error_flag_q, flg_wdt_q};
                A_MODE:   rdata_d = {31'h0, bus_error_response_ctrl_q};
                A_KEEP:   rdata_d = keep_q;
                default:  rdata_d = 32'h0000_0000;
            endcase
        end
        if (reg_write) begin
            unique case (reg_addr)
                A_STATUS: begin
                    // Boot-vector bit taken from write data bit 0; software may clear it
                    boot_vec_d = reg_wdata[0];
                    iv_split_d = reg_wdata[1];
                    erl_d = reg_wdata[2];
                    nmi_bit_d = reg_wdata[3];
                end
                A_CAUSE:  cause_d = reg_wdata[4:0];
                A_EPC:    epc_d = reg_wdata;
                A_ERREPC: err_epc_d = reg_wdata;
                A_SHADOW: begin
                    css_d = reg_wdata[SHADOW_W-1:0];
                    pss_d = reg_wdata[8 +: SHADOW_W];
                    ssd_d = reg_wdata[16];
                end
                A_NMICFG: begin
                    sense_d = reg_wdata[1:0];
                    wdsel_d = reg_wdata[2];
                end
                // Write one to clear; a new cause in the same cycle wins below
                A_NMI_CAUSE_FLAGS: begin
                    flg_wdt_d  = flg_wdt_q && !reg_wdata[0];
                    flg_store_bus_error_flag_d = flg_store_bus_error_flag_q && !reg_wdata[1];
                end
                A_MODE:   bus_error_response_ctrl_d = reg_wdata[0];
                A_KEEP:   keep_d = reg_wdata;
                default:  ;
            endcase
        end
        if (eret && !ssd_q) begin
            css_d = pss_q;
        end

        if (wdt_nmi_ev) begin
            flg_wdt_d = 1'b1;
            wdt_nmi_done_d = 1'b1;
        end
        if (store_bus_error && !bus_error_response_ctrl_q) begin
            flg_store_bus_error_flag_d = 1'b1;
        end

        if (reset_ev) begin
            valid_d = 1'b1;
            kind_d = XVE_EV_RESET;
            vec_d = `XVE_VEC_RESET_NMI;
            pinit_d = 1'b1;
            err_epc_d = current_pc;
            erl_d = `XVE_RST_ERL;
            boot_vec_d = `XVE_RST_BOOT_VEC;
            iv_split_d = `XVE_RST_IVSPLIT;
            nmi_bit_d = 1'b0;
            cause_d = `XVE_RST_CAUSE;
            css_d = SHADOW_W'(`XVE_RST_SHADOW);
            pss_d = SHADOW_W'(`XVE_RST_SHADOW);
            ssd_d = 1'b0;
            sense_d = `XVE_RST_NMISENSE;
            wdsel_d = `XVE_RST_WDSEL;
            bus_error_response_ctrl_d = `XVE_RST_BUS_ERROR_RESPONSE_CTRL;
            wdt_nmi_done_d = 1'b0;
            flg_wdt_d = 1'b0;
            flg_store_bus_error_flag_d = 1'b0;
            // On mask parts pin reset clears the keep register and watchdog reset leaves it
            if (!FLASH_VARIANT && !reset_pin_n) begin
                keep_d = 32'h0000_0000;
            end
        end else if (nmi_ev) begin
            valid_d = 1'b1;
            kind_d = XVE_EV_NMI;
            vec_d = `XVE_VEC_RESET_NMI;
            erl_d = 1'b1;
            nmi_bit_d = 1'b1;
            err_epc_d = current_pc;
            if (!ssd_q) begin
                pss_d = css_q;
            end
        end else if (dbg_ev) begin
            valid_d = 1'b1;
            kind_d = XVE_EV_DEBUG;
            // No shadow set update for debug entries
            vec_d = debug_probe_enable ? `XVE_VEC_DBG_PROBE : `XVE_VEC_DBG_NOPROBE;
        end else if (gen_ev) begin
            valid_d = 1'b1;
            kind_d = XVE_EV_GENERAL;
            cause_d = gen_info.cause;
            // Async data errors already carry the PC of the instruction in execution
            epc_d = current_pc;
            if (gen_info.addr_err || gen_info.bus_err) begin
                bad_d = gen_info.bad_addr;
            end
            if (!ssd_q) begin
                pss_d = css_q;
            end
            if (gen_info.is_int) begin
                if (boot_vec_q) begin
                    vec_d = iv_split_q ? `XVE_VEC_INT_BEV1_IV : `XVE_VEC_GEN_BEV1;
                end else begin
                    vec_d = iv_split_q ? `XVE_VEC_INT_BEV0_IV : `XVE_VEC_GEN_BEV0;
                end
            end else begin
                vec_d = boot_vec_q ? `XVE_VEC_GEN_BEV1 : `XVE_VEC_GEN_BEV0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            boot_vec_q <= `XVE_RST_BOOT_VEC;
            iv_split_q <= `XVE_RST_IVSPLIT;
            erl_q <= `XVE_RST_ERL;
            nmi_bit_q <= 1'b0;
            cause_q <= `XVE_RST_CAUSE;
            epc_q <= 32'h0000_0000;
            err_epc_q <= 32'h0000_0000;
            bad_q <= 32'h0000_0000;
            css_q <= SHADOW_W'(`XVE_RST_SHADOW);
            pss_q <= SHADOW_W'(`XVE_RST_SHADOW);
            ssd_q <= 1'b0;
            sense_q <= `XVE_RST_NMISENSE;
            wdsel_q <= `XVE_RST_WDSEL;
            bus_error_response_ctrl_q <= `XVE_RST_BUS_ERROR_RESPONSE_CTRL;
            flg_wdt_q <= 1'b0;
            flg_store_bus_error_flag_q <= 1'b0;
            wdt_nmi_done_q <= 1'b0;
            nmi_pin_q <= 1'b0;
            reg_rdata <= 32'h0000_0000;
            entry_valid <= 1'b0;
            entry_vector <= `XVE_VEC_RESET_NMI;
            entry_kind <= XVE_EV_NONE;
            periph_init <= 1'b0;
            dma_conf_error <= 1'b0;
        end else begin
            boot_vec_q <= boot_vec_d;
            iv_split_q <= iv_split_d;
            erl_q <= erl_d;
            nmi_bit_q <= nmi_bit_d;
            cause_q <= cause_d;
            epc_q <= epc_d;
            err_epc_q <= err_epc_d;
            bad_q <= bad_d;
            css_q <= css_d;
            pss_q <= pss_d;
            ssd_q <= ssd_d;
            sense_q <= sense_d;
            wdsel_q <= wdsel_d;
            bus_error_response_ctrl_q <= bus_error_response_ctrl_d;
            flg_wdt_q <= flg_wdt_d;
            flg_store_bus_error_flag_q <= flg_store_bus_error_flag_d;
            wdt_nmi_done_q <= wdt_nmi_done_d;
            nmi_pin_q <= nmi_pin_d;
            reg_rdata <= rdata_d;
            entry_valid <= valid_d;
            entry_vector <= vec_d;
            entry_kind <= kind_d;
            periph_init <= pinit_d;
            dma_conf_error <= dmaerr_d;
        end
    end

    // Flash parts keep this register through reset exceptions; only power-on clears it
    always_ff @(posedge clk) begin
        if (FLASH_VARIANT && power_on_reset) begin
            keep_q <= 32'h0000_0000;
        end else if (!FLASH_VARIANT && reset) begin
            keep_q <= 32'h0000_0000;
        end else begin
            keep_q <= keep_d;
        end
    end
endmodule // xve_entry

/* xve_entry_properties.sv */
// Port-level checks for the exception entry block
`timescale 1ns/1ps
module xve_entry_properties
    import xve_pkg::*;
(
    input wire logic         clk,
    input wire logic         reset,
    input wire logic         reset_pin_n,
    input wire logic         wdt_timeout,
    input wire logic         wdt_overflow,
    input wire logic         nmi_pin_function_bit,
    input wire logic         store_bus_error,
    input wire logic         debug_req,
    input wire logic         debug_probe_enable,
    input wire logic         gen_req,
    input wire xve_gen_req_t gen_info,
    input wire logic         entry_valid,
    input wire logic  [31:0] entry_vector,
    input wire xve_event_t   entry_kind,
    input wire logic         periph_init,
    input wire logic         dma_conf_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Watchdog events may mean reset or NMI, so they count as higher priority
    logic no_high;
    assign no_high = reset_pin_n && !store_bus_error && !wdt_timeout && !wdt_overflow && !nmi_pin_function_bit;
    a_reset_entry: assert property (
        !reset_pin_n |=> entry_valid && entry_kind == XVE_EV_RESET && periph_init)
        else $error("reset pin gave no reset entry");
    a_fixed_vector: assert property (
        entry_valid && entry_kind inside {XVE_EV_RESET, XVE_EV_NMI} |-> entry_vector == 32'hBFC0_0000)
        else $error("reset or nmi vector wrong");
    a_debug_vector: assert property (
        debug_req && no_high |=> entry_valid && entry_kind == XVE_EV_DEBUG &&
        entry_vector == ($past(debug_probe_enable) ? 32'hFF20_0200 : 32'hBFC0_0480))
        else $error("debug vector wrong");
    a_general_vector: assert property (
        entry_valid && entry_kind == XVE_EV_GENERAL |->
        entry_vector inside {32'h8000_0180, 32'h8000_0200, 32'hBFC0_0380, 32'hBFC0_0400})
        else $error("general vector outside table");
    a_dma_addr_err: assert property (
        gen_req && gen_info.dma && gen_info.addr_err && !debug_req && no_high |=> dma_conf_error && !entry_valid)
        else $error("dma address error not diverted");
    a_dma_load_bus: assert property (
        gen_req && gen_info.dma && gen_info.bus_err && gen_info.is_load && !gen_info.addr_err && !debug_req && no_high
        |=> entry_valid && entry_kind == XVE_EV_GENERAL)
        else $error("dma load bus error gave no entry");
    a_init_on_reset: assert property (
        periph_init |-> entry_valid && entry_kind == XVE_EV_RESET)
        else $error("peripheral init without reset entry");
    a_kind_valid: assert property (
        entry_valid == (entry_kind != XVE_EV_NONE))
        else $error("entry kind and valid disagree");
    a_quiet_no_entry: assert property (
        !gen_req && !debug_req && no_high |=> !entry_valid)
        else $error("entry without request");
    a_vector_holds: assert property (
        !entry_valid && !$past(reset) |-> $stable(entry_vector))
        else $error("vector moved without entry");
endmodule // xve_entry_properties

bind xve_entry xve_entry_properties i_props (.clk, .reset, .reset_pin_n, .wdt_timeout, .wdt_overflow,
    .nmi_pin_function_bit, .store_bus_error, .debug_req, .debug_probe_enable, .gen_req, .gen_info,
    .entry_valid, .entry_vector, .entry_kind, .periph_init, .dma_conf_error);

/* xve_pipe_model.sv */
// Pipeline stand-in that advances the executing PC
`timescale 1ns/1ps
module xve_pipe_model (
    input  wire logic        clk,
    input  wire logic        reset,
    output logic      [31:0] current_pc
);
    // Mixed 16/32-bit steps so a stale saved PC shows up
    always_ff @(posedge clk) begin
        if (reset) begin
            current_pc <= 32'hBFC0_0000;
        end else begin
            current_pc <= current_pc + 32'($urandom_range(1, 2)) * 32'h2;
        end
    end
endmodule // xve_pipe_model

/* xve_entry_tb_top.sv */
// Self-checking bench for the exception entry block
`timescale 1ns/1ps
module xve_entry_tb_top
    import xve_pkg::*;
;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic         power_on_reset = 1'b1;
    logic         reset_pin_n = 1'b1;
    logic         wdt_timeout = 1'b0;
    logic         wdt_overflow = 1'b0;
    logic         store_bus_error = 1'b0;
    logic         debug_req = 1'b0;
    logic         debug_probe_enable = 1'b0;
    logic         nmi_pin = 1'b1;
    logic         nmi_pin_function_bit = 1'b0;
    logic         eret = 1'b0;
    logic         gen_req = 1'b0;
    xve_gen_req_t gen_info = '0;
    logic         reg_write = 1'b0;
    logic         reg_read = 1'b0;
    logic [7:0]   reg_addr = 8'h0;
    logic [31:0]  reg_wdata = 32'h0;
    logic [31:0]  current_pc;
    logic [31:0]  reg_rdata;
    logic [31:0]  entry_vector;
    xve_event_t   entry_kind;
    logic         entry_valid;
    logic         periph_init;
    logic         dma_conf_error;
    logic [34:0]  exp_entries[$];
    logic [31:0]  exp_reads[$];
    logic [31:0]  pc_taken;
    logic [34:0]  e;
    xve_gen_req_t g;
    int           compares = 0;
    int           miscompares = 0;
    int           dma_seen = 0;
    bit           rd_pend = 0;

    always #12.5 clk = ~clk;

    xve_entry i_dut (.clk, .reset, .power_on_reset, .reset_pin_n, .wdt_timeout, .wdt_overflow,
        .nmi_pin, .nmi_pin_function_bit, .store_bus_error, .debug_req, .debug_probe_enable,
        .gen_req, .gen_info, .current_pc, .eret, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .entry_valid, .entry_vector, .entry_kind, .periph_init, .dma_conf_error);
    xve_pipe_model i_pipe (.clk, .reset, .current_pc);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        reg_read <= 1'b1;
        reg_addr <= a;
        exp_reads.push_back(x);
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
    endtask

    // Mask bits: gen, debug, store error, reset pin, wdt timeout, wdt overflow
    task automatic fire(input logic [5:0] m, input xve_gen_req_t gi, input xve_event_t k, input logic [31:0] v);
        {wdt_overflow, wdt_timeout, store_bus_error, debug_req, gen_req} <= {m[5:4], m[2:0]};
        reset_pin_n <= !m[3];
        gen_info <= gi;
        @(posedge clk);
        pc_taken = current_pc;
        {wdt_overflow, wdt_timeout, store_bus_error, debug_req, gen_req} <= 5'h0;
        reset_pin_n <= 1'b1;
        if (k != XVE_EV_NONE) exp_entries.push_back({k, v});
        @(posedge clk);
    endtask

    function automatic logic [31:0] gen_vec(input bit boot_vector_select, input bit iv, input bit is_int);
        if (is_int && iv) return boot_vector_select ? 32'hBFC0_0400 : 32'h8000_0200;
        return boot_vector_select ? 32'hBFC0_0380 : 32'h8000_0180;
    endfunction

    // Results are matched in order against the notes left by the drivers
    always @(posedge clk) begin
        if (rd_pend) check("reg_rdata", reg_rdata, exp_reads.pop_front());
        rd_pend = reg_read;
        if (entry_valid === 1'b1) begin
            e = (exp_entries.size() != 0) ? exp_entries.pop_front() : 35'h0;
            check("entry_vector", entry_vector, e[31:0]);
            check("entry_kind", 32'(entry_kind), 32'(e[34:32]));
            check("periph_init", 32'(periph_init), 32'(e[34:32] == XVE_EV_RESET));
        end
        if (dma_conf_error === 1'b1) dma_seen++;
    end

    initial begin
        void'($urandom(32'h2A90));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        power_on_reset <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h5);
        rd(8'hFC, 32'h0);
        wr(8'h24, 32'h1);
        for (int b = 0; b < 2; b++) begin
            for (int v = 0; v < 4; v++) begin
                g = '0;
                g.is_int = v[1];
                g.cause = v[1] ? 5'h00 : 5'h08;
                wr(8'h00, {30'h0, v[0], b[0]});
                fire(6'h01, g, XVE_EV_GENERAL, gen_vec(b[0], v[0], v[1]));
            end
        end
        wr(8'h00, 32'h1);
        for (int p = 1; p >= 0; p--) begin
            debug_probe_enable <= p[0];
            fire(6'h02, '0, XVE_EV_DEBUG, p ? 32'hFF20_0200 : 32'hBFC0_0480);
        end
        g = '0;
        g.addr_err = 1'b1;
        g.cause = 5'($urandom_range(4, 5));
        g.bad_addr = $urandom;
        fire(6'h01, g, XVE_EV_GENERAL, 32'hBFC0_0380);
        rd(8'h04, {27'h0, g.cause});
        rd(8'h08, pc_taken);
        rd(8'h10, g.bad_addr);
        wr(8'h14, 32'h3);
        fire(6'h01, '0, XVE_EV_GENERAL, 32'hBFC0_0380);
        rd(8'h14, 32'h303);
        wr(8'h14, 32'h5);
        fire(6'h02, '0, XVE_EV_DEBUG, 32'hBFC0_0480);
        rd(8'h14, 32'h5);
        fire(6'h04, '0, XVE_EV_NMI, 32'hBFC0_0000);
        rd(8'h0C, pc_taken);
        rd(8'h14, 32'h505);
        rd(8'h00, 32'hD);
        // A return takes the previous set back as current
        wr(8'h14, 32'h203);
        eret <= 1'b1;
        @(posedge clk);
        eret <= 1'b0;
        @(posedge clk);
        rd(8'h14, 32'h202);
        rd(8'h1C, 32'h2);
        wr(8'h1C, 32'h2);
        rd(8'h1C, 32'h0);
        wr(8'h20, 32'h1);
        fire(6'h04, '0, XVE_EV_NONE, 32'h0);
        wr(8'h20, 32'h0);
        g = '0;
        g.dma = 1'b1;
        g.addr_err = 1'b1;
        fire(6'h01, g, XVE_EV_NONE, 32'h0);
        @(posedge clk);
        check("dma_conf_error", 32'(dma_seen), 32'h1);
        g.addr_err = 1'b0;
        g.bus_err = 1'b1;
        g.is_load = 1'b1;
        g.async_data = 1'b1;
        g.bad_addr = $urandom;
        fire(6'h01, g, XVE_EV_GENERAL, 32'hBFC0_0380);
        rd(8'h08, pc_taken);
        rd(8'h10, g.bad_addr);
        // Falling pin edge: ignored while the pin function bit is clear, taken once it is set
        wr(8'h18, 32'h1);
        for (int f = 0; f < 2; f++) begin
            nmi_pin_function_bit <= f[0];
            nmi_pin <= 1'b0;
            if (f == 1) exp_entries.push_back({XVE_EV_NMI, 32'hBFC0_0000});
            @(posedge clk);
            pc_taken = current_pc;
            nmi_pin <= 1'b1;
            @(posedge clk);
        end
        nmi_pin_function_bit <= 1'b0;
        rd(8'h0C, pc_taken);
        wr(8'h1C, 32'h3);
        wr(8'h18, 32'h0);
        fire(6'h10, '0, XVE_EV_NMI, 32'hBFC0_0000);
        rd(8'h1C, 32'h1);
        fire(6'h20, '0, XVE_EV_RESET, 32'hBFC0_0000);
        rd(8'h00, 32'h5);
        rd(8'h24, 32'h1);
        wr(8'h18, 32'h4);
        fire(6'h10, '0, XVE_EV_RESET, 32'hBFC0_0000);
        rd(8'h0C, pc_taken);
        fire(6'h0F, '0, XVE_EV_RESET, 32'hBFC0_0000);
        fire(6'h06, '0, XVE_EV_NMI, 32'hBFC0_0000);
        for (int k = 0; k < 10 && exp_entries.size() != 0; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        if (exp_entries.size() != 0) miscompares++;
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule // xve_entry_tb_top
